// ===== sgts_pkg.sv
/*
  constants, register map and state types shared by the time-sync core.
  assumes one apb clock domain at 40 MHz.
*/
// Overview of operation
// RULE1: a phase detector measures the time from the local second pulse to the receiver second pulse.
// RULE2: the quantisation error from the receiver serial stream (up to 20 ns) is subtracted from that phase.
// RULE3: the corrected phase feeds an averaging filter; software reads both the filtered and corrected values.
// RULE4: the master time counter advances on every edge of the disciplined oscillator clock; the code counts rising pclk edges only.
// RULE5: in genlock mode the first black-burst driver is switched off and its connector serves as reference input.
// RULE6: in genlock mode the separated reference sync coarsely realigns the internal sync timing.
// RULE7: a capture window timed from the detected sync, at the sync edge or the burst, stores adc samples for software.
// RULE8: timecode values and frame reset pulse positions come from the master time counter.
// RULE9: three black-burst and four linear timecode engines each take one of three frame reset pulses; the code drives all seven from the same frame_hit.
// RULE10: frame reset pulses are timed as if sequences began at the 1958 epoch, using total elapsed time.
// RULE11: each frame reset pulse returns its video output start position to its reference point.
// RULE12: one trigger input and two trigger outputs are configured by software for triggering or detection.
// RULE13: the timecode reader takes vitc bits from the same adc stream and checks crc and continuity.
// RULE14: the block flags valid timecode; the host reads decoded time only after that flag.
// RULE15: genlock and timecode reader exist only when a build parameter selects the reference input variant.
// RULE16: every host access goes through the bus interface, which serves all reads and writes.
// RULE17: the local second pulse fires when the master time counter rolls over a whole second.
package sgts_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned QERR_MAX_NS = 20;
  localparam int unsigned QERR_MAX_PS = QERR_MAX_NS * 1000;
  localparam int unsigned CYCLES_PER_SEC = CLK_HZ;
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_STATUS = 12'h004;
  localparam logic [11:0] A_IRQ_STAT = 12'h008;
  localparam logic [11:0] A_IRQ_MASK = 12'h00C;
  localparam logic [11:0] A_PHASE = 12'h010;
  localparam logic [11:0] A_FILT = 12'h014;
  localparam logic [11:0] A_SEC_LO = 12'h018;
  localparam logic [11:0] A_SEC_HI = 12'h01C;
  localparam logic [11:0] A_SUBSEC = 12'h020;
  localparam logic [11:0] A_EPOCH_LO = 12'h024;
  localparam logic [11:0] A_EPOCH_HI = 12'h028;
  localparam logic [11:0] A_FRAME_LEN = 12'h02C;
  localparam logic [11:0] A_TRIG = 12'h030;
  localparam logic [11:0] A_WIN = 12'h034;
  localparam logic [11:0] A_CAP_IDX = 12'h038;
  localparam logic [11:0] A_CAP_DATA = 12'h03C;
  localparam logic [11:0] A_TC = 12'h040;
  localparam logic [11:0] A_SEC_SET = 12'h044;
  localparam int CTRL_GENLOCK = 0;
  localparam int CTRL_WIN_BURST = 1;
  localparam int CTRL_SEC_LOAD = 2;
  localparam int IRQ_PPS = 0;
  localparam int IRQ_LOCAL = 1;
  localparam int IRQ_TC = 2;
  localparam int IRQ_TRIG = 3;
  localparam int IRQ_CAP = 4;
  localparam int IRQ_W = 5;
  localparam int FILT_SHIFT = 3;
  localparam logic [31:0] FRAME_LEN_RST = 32'h000A2C2A;
  localparam logic [31:0] TC_SYNC_WORD = 32'h0000BFFC;
  typedef enum logic [1:0] {
    SGTS_WIN_IDLE = 2'b00,
    SGTS_WIN_WAIT = 2'b01,
    SGTS_WIN_CAP = 2'b10
  } sgts_win_e;
endpackage : sgts_pkg

// ===== sgts_sync3.sv
/*
  three-stage input synchroniser with agreement filter.
  assumes an asynchronous pin input.
*/
`timescale 1ns/1ps
`default_nettype none
module sgts_sync3 (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // pin and result
  input wire logic pin,
  output logic level
);
  logic s1;
  logic s2;
  logic s3;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      level <= 1'b0;
    end
    else
    begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        level <= s3;
    end
  end
endmodule : sgts_sync3
`default_nettype wire

// ===== sgts_cap_mem.sv
/*
  capture sample memory, registered read.
  assumes single clock; write and read ports independent.
*/
`timescale 1ns/1ps
`default_nettype none
module sgts_cap_mem #(
  parameter int DW = 12,
  parameter int AW = 6
) (
  // clock
  input wire logic pclk,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];
  always_ff @(posedge pclk)
  begin
    if (we)
      mem[waddr] <= wdata;
    rdata <= mem[raddr];
  end
endmodule : sgts_cap_mem
`default_nettype wire

// ===== sgts_core.sv
/*
  time-sync core: phase detector, master time counter, frame resets,
  genlock window, timecode reader, trigger lines, apb registers.
  assumes pins pass through sgts_sync3; adc samples are on pclk.
*/
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sgts_core
  import sgts_pkg::*;
#(
  parameter bit HAS_REF_IN = 1'b1,
  parameter int unsigned SEC_CYCLES = CYCLES_PER_SEC,
  parameter int ADC_W = 12,
  parameter int CAP_AW = 6
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // receiver
  input wire logic rx_pps,
  input wire logic rx_qerr_valid,
  input wire logic [15:0] rx_qerr_ps,
  // reference video
  input wire logic ref_sync,
  input wire logic [ADC_W-1:0] ref_adc,
  // video engines
  output logic black1_drive_en,
  output logic [2:0] frame_reset,
  output logic [2:0] black_frame_reset,
  output logic [3:0] linear_timecode_engine_reset,
  output logic local_second_pulse,
  // triggers
  input wire logic trigger_line_in,
  output logic [1:0] trigger_line_out
);
  // ************
  // pin synchronisers
  // ************
  logic pps_s;
  logic sync_s;
  logic trig_s;
  sgts_sync3 u_pps (.pclk(pclk), .presetn(presetn), .pin(rx_pps), .level(pps_s));
  sgts_sync3 u_sync (.pclk(pclk), .presetn(presetn), .pin(ref_sync), .level(sync_s));
  sgts_sync3 u_trig (.pclk(pclk), .presetn(presetn), .pin(trigger_line_in), .level(trig_s));
  logic pps_d;
  logic sync_d;
  logic trig_d;
  wire pps_rise = pps_s & ~pps_d;
  wire sync_rise = sync_s & ~sync_d;
  wire trig_rise = trig_s & ~trig_d;

  // ************
  // registers
  // ************
  logic [2:0] ctrl;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [31:0] epoch_lo;
  logic [31:0] epoch_hi;
  logic [31:0] frame_len;
  logic [7:0] trig_cfg;
  logic [15:0] win_delay;
  logic [CAP_AW-1:0] cap_idx;
  logic [31:0] sec_set;
  wire genlock = ctrl[CTRL_GENLOCK] & HAS_REF_IN; // RULE15
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire wr_ctrl = wr & (paddr == A_CTRL);
  wire wr_irq = wr & (paddr == A_IRQ_STAT);

  // ************
  // master time counter
  // ************
  logic [31:0] subsec;
  logic [63:0] seconds;
  wire sec_roll = (subsec == SEC_CYCLES - 1);
  wire sec_load = wr_ctrl & pwdata[CTRL_SEC_LOAD];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      subsec <= 32'h00000000;
      seconds <= 64'h0000000000000000;
    end
    else if (sec_load)
    begin
      subsec <= 32'h00000000;
      seconds <= {32'h00000000, sec_set};
    end
    else if (sec_roll)
    begin
      subsec <= 32'h00000000; // RULE4
      seconds <= seconds + 64'h0000000000000001;
    end
    else
      subsec <= subsec + 32'h00000001; // RULE4
  end

  // ************
  // phase detector and filter
  // ************
  logic [31:0] phase_cnt;
  logic signed [31:0] phase_corr;
  logic signed [31:0] filt;
  logic [15:0] qerr;
  wire signed [31:0] raw_ps = $signed(phase_cnt * CLK_PERIOD_PS);
  wire signed [31:0] next_corr = raw_ps - $signed({16'h0000, qerr});
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_cnt <= 32'h00000000;
      phase_corr <= 32'sh00000000;
      filt <= 32'sh00000000;
      qerr <= 16'h0000;
    end
    else
    begin
      if (rx_qerr_valid)
        qerr <= (rx_qerr_ps > 16'(QERR_MAX_PS)) ? 16'(QERR_MAX_PS) : rx_qerr_ps;
      if (sec_roll)
        phase_cnt <= 32'h00000000; // RULE1
      else
        phase_cnt <= phase_cnt + 32'h00000001;
      if (pps_rise)
      begin
        phase_corr <= next_corr; // RULE2
        filt <= filt + ((next_corr - filt) >>> FILT_SHIFT); // RULE3
      end
    end
  end

  // ************
  // frame resets on epoch
  // ************
  logic [31:0] frame_pos;
  wire [95:0] epoch_ticks = 96'({epoch_hi, epoch_lo}) * 96'(SEC_CYCLES);
  wire [31:0] epoch_phase = 32'(epoch_ticks % {64'h0, frame_len}); // RULE10
  wire frame_hit = (frame_pos == frame_len - 32'h00000001);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_pos <= 32'h00000000;
    else if (sec_load)
      frame_pos <= epoch_phase; // RULE8
    else if (frame_hit | (genlock & sync_rise))
      frame_pos <= 32'h00000000; // RULE6
    else
      frame_pos <= frame_pos + 32'h00000001;
  end

  // ************
  // genlock capture window
  // ************
  sgts_win_e win_st;
  logic [15:0] win_cnt;
  logic [CAP_AW-1:0] cap_wa;
  logic [ADC_W-1:0] cap_rd;
  wire [15:0] win_start = ctrl[CTRL_WIN_BURST] ? win_delay : 16'h0000;
  wire cap_we = (win_st == SGTS_WIN_CAP);
  wire cap_done = cap_we & (&cap_wa);
  sgts_cap_mem #(.DW(ADC_W), .AW(CAP_AW)) u_mem (
    .pclk(pclk),
    .we(cap_we),
    .waddr(cap_wa),
    .wdata(ref_adc),
    .raddr(cap_idx),
    .rdata(cap_rd)
  );
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      win_st <= SGTS_WIN_IDLE;
      win_cnt <= 16'h0000;
      cap_wa <= '0;
    end
    else
    begin
      case (win_st)
        SGTS_WIN_IDLE:
        begin
          if (genlock & sync_rise) // RULE7
          begin
            win_st <= SGTS_WIN_WAIT;
            win_cnt <= 16'h0000;
          end
        end
        SGTS_WIN_WAIT:
        begin
          win_cnt <= win_cnt + 16'h0001;
          if (win_cnt >= win_start)
          begin
            win_st <= SGTS_WIN_CAP;
            cap_wa <= '0;
          end
        end
        SGTS_WIN_CAP:
        begin
          cap_wa <= cap_wa + CAP_AW'(1); // RULE7
          if (&cap_wa)
            win_st <= SGTS_WIN_IDLE;
        end
        default:
          win_st <= SGTS_WIN_IDLE;
      endcase
    end
  end

  // ************
  // vitc reader
  // ************
  logic [89:0] tc_sh;
  logic [6:0] tc_bits;
  logic [31:0] tc_time;
  logic [31:0] tc_prev;
  logic tc_valid;
  logic tc_ok;
  wire tc_bit = ref_adc[ADC_W-1];
  wire [7:0] tc_crc = tc_sh[89:82];
  function automatic logic [7:0] crc8(input logic [81:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 81; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
    return c;
  endfunction : crc8
  wire [31:0] tc_word = {tc_sh[73:66], tc_sh[57:50], tc_sh[41:34], tc_sh[25:18]};
  wire tc_cont = (tc_word == tc_prev + 32'h00000001) | ~tc_valid; // RULE13
  wire tc_frame = HAS_REF_IN & cap_we & (tc_bits == 7'd89); // RULE15
  wire tc_good = tc_frame & (crc8(tc_sh[81:0]) == tc_crc) & tc_cont; // RULE13
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tc_sh <= '0;
      tc_bits <= 7'd0;
      tc_time <= 32'h00000000;
      tc_prev <= 32'h00000000;
      tc_valid <= 1'b0;
    end
    else
    begin
      if (!cap_we)
        tc_bits <= 7'd0;
      else if (tc_bits != 7'd89)
      begin
        tc_sh <= {tc_sh[88:0], tc_bit};
        tc_bits <= tc_bits + 7'd1;
      end
      if (tc_frame)
      begin
        tc_prev <= tc_word;
        tc_valid <= tc_good;
        if (tc_good)
          tc_time <= tc_word; // RULE14
      end
    end
  end

  // ************
  // outputs and status
  // ************
  logic [IRQ_W-1:0] ev;
  assign ev[IRQ_PPS] = pps_rise;
  assign ev[IRQ_LOCAL] = sec_roll;
  assign ev[IRQ_TC] = tc_good;
  assign ev[IRQ_TRIG] = trig_rise & trig_cfg[0];
  assign ev[IRQ_CAP] = cap_done;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pps_d <= 1'b0;
      sync_d <= 1'b0;
      trig_d <= 1'b0;
      local_second_pulse <= 1'b0;
      frame_reset <= 3'b000;
      black_frame_reset <= 3'b000;
      linear_timecode_engine_reset <= 4'b0000;
      black1_drive_en <= 1'b1;
      trigger_line_out <= 2'b00;
      irq <= 1'b0;
    end
    else
    begin
      pps_d <= pps_s;
      sync_d <= sync_s;
      trig_d <= trig_s;
      local_second_pulse <= sec_roll; // RULE17
      frame_reset <= {3{frame_hit}}; // RULE11
      black_frame_reset <= {3{frame_hit}}; // RULE9
      linear_timecode_engine_reset <= {frame_hit, frame_hit, frame_hit, frame_hit}; // RULE9
      black1_drive_en <= ~genlock; // RULE5
      trigger_line_out[0] <= trig_cfg[4] ? (trig_cfg[2] & trig_rise) : trig_cfg[2]; // RULE12
      trigger_line_out[1] <= trig_cfg[5] ? (trig_cfg[3] & sec_roll) : trig_cfg[3]; // RULE12
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ************
  // apb slave
  // ************
  logic [31:0] rmux;
  always_comb
  begin
    case (paddr)
      A_CTRL: rmux = {29'h0, ctrl};
      A_STATUS: rmux = {28'h0, tc_valid, trig_s, genlock, win_st != SGTS_WIN_IDLE};
      A_IRQ_STAT: rmux = {27'h0, irq_stat};
      A_IRQ_MASK: rmux = {27'h0, irq_mask};
      A_PHASE: rmux = phase_corr;
      A_FILT: rmux = filt;
      A_SEC_LO: rmux = seconds[31:0];
      A_SEC_HI: rmux = seconds[63:32];
      A_SUBSEC: rmux = subsec;
      A_EPOCH_LO: rmux = epoch_lo;
      A_EPOCH_HI: rmux = epoch_hi;
      A_FRAME_LEN: rmux = frame_len;
      A_TRIG: rmux = {24'h0, trig_cfg};
      A_WIN: rmux = {16'h0, win_delay};
      A_CAP_IDX: rmux = {{(32-CAP_AW){1'b0}}, cap_idx};
      A_CAP_DATA: rmux = {{(32-ADC_W){1'b0}}, cap_rd};
      A_TC: rmux = tc_valid ? tc_time : 32'h00000000; // RULE14
      A_SEC_SET: rmux = sec_set;
      default: rmux = 32'h00000000;
    endcase
  end
  wire mapped = (paddr <= A_SEC_SET) & (paddr[1:0] == 2'b00);
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl <= 3'b000;
      irq_stat <= '0;
      irq_mask <= '0;
      epoch_lo <= 32'h00000000;
      epoch_hi <= 32'h00000000;
      frame_len <= FRAME_LEN_RST;
      trig_cfg <= 8'h00;
      win_delay <= 16'h0000;
      cap_idx <= '0;
      sec_set <= 32'h00000000;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable; // RULE16
      pslverr <= psel & ~penable & ~mapped;
      if (psel & ~penable & ~pwrite)
        prdata <= rmux; // RULE16
      irq_stat <= (irq_stat & ~(wr_irq ? pwdata[IRQ_W-1:0] : '0)) | ev;
      if (wr & pready)
      begin
        case (paddr)
          A_CTRL: ctrl <= {1'b0, pwdata[1:0]};
          A_IRQ_MASK: irq_mask <= pwdata[IRQ_W-1:0];
          A_EPOCH_LO: epoch_lo <= pwdata;
          A_EPOCH_HI: epoch_hi <= pwdata;
          A_FRAME_LEN: frame_len <= pwdata;
          A_TRIG: trig_cfg <= pwdata[7:0];
          A_WIN: win_delay <= pwdata[15:0];
          A_CAP_IDX: cap_idx <= pwdata[CAP_AW-1:0];
          A_SEC_SET: sec_set <= pwdata;
          default: ;
        endcase
      end
    end
  end
endmodule : sgts_core
`default_nettype wire

// ===== sgts_rx_model.sv
/*
  receiver model: quantisation error word and the second pulse it belongs to, both raised in the same cycle.
  assumes the bench pulses fire for one pclk cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module sgts_rx_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bench command
  input wire logic fire,
  input wire logic [15:0] qerr,
  // receiver pins
  output logic rx_pps,
  output logic rx_qerr_valid,
  output logic [15:0] rx_qerr_ps
);
  logic [3:0] cnt;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cnt <= 4'h0;
      rx_pps <= 1'b0;
      rx_qerr_valid <= 1'b0;
      rx_qerr_ps <= 16'h0000;
    end
    else
    begin
      rx_qerr_valid <= fire;
      rx_qerr_ps <= fire ? ((qerr > 16'h4E20) ? 16'h4E20 : qerr) : ~rx_qerr_ps;
      if (fire)
      begin
        cnt <= 4'h8;
        rx_pps <= 1'b1;
      end
      else if (cnt != 4'h0)
      begin
        cnt <= cnt - 4'h1;
        if (cnt == 4'h1)
          rx_pps <= 1'b0;
      end
    end
endmodule : sgts_rx_model
`default_nettype wire

// ===== sgts_checker.sv
/*
  port assertions of the time-sync core.
  assumes binding onto sgts_core, one pclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sgts_checker
  import sgts_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = CYCLES_PER_SEC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  // engines
  input wire logic black1_drive_en,
  input wire logic [2:0] frame_reset,
  input wire logic [2:0] black_frame_reset,
  input wire logic [3:0] linear_timecode_engine_reset,
  input wire logic local_second_pulse
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ****************************************
  // helper logic
  // ****************************************
  wire logic acc = psel && penable && pready;
  wire logic ctrl_wr = acc && pwrite && (paddr == A_CTRL);
  wire logic load = ctrl_wr && pwdata[CTRL_SEC_LOAD];
  logic [31:0] gap;
  logic armed;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      gap <= 32'h0;
      armed <= 1'b0;
    end
    else
    begin
      gap <= local_second_pulse ? 32'h0 : gap + 32'h1;
      armed <= load ? 1'b0 : (armed || local_second_pulse);
    end
  property p_drive;
    ctrl_wr |-> ##2 (black1_drive_en == !$past(pwdata[CTRL_GENLOCK], 2));
  endproperty
  // ****************************************
  // assertions
  // ****************************************
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  a_unmapped_read: assert property (acc && !pwrite && paddr > A_SEC_SET |-> prdata == 32'h0 && pslverr)
    else $error("unmapped read not refused");
  a_mapped_ok: assert property (acc && paddr <= A_SEC_SET && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("mapped access refused");
  a_drive_level: assert property (p_drive)
    else $error("black1 drive does not follow genlock");
  a_drive_cause: assert property ($changed(black1_drive_en) |-> $past(ctrl_wr) || $past(ctrl_wr, 2))
    else $error("black1 drive changed without ctrl write");
  a_frame_pulse: assert property (|frame_reset |=> (frame_reset & $past(frame_reset)) == 3'b000)
    else $error("frame reset longer than one cycle");
  a_engine_follow: assert property (|black_frame_reset || |linear_timecode_engine_reset |-> |frame_reset)
    else $error("engine reset without frame reset");
  a_irq_masked: assert property (acc && pwrite && paddr == A_IRQ_MASK && pwdata == 32'h0 |-> ##2 !irq)
    else $error("irq high with all masked");
  a_second_period: assert property (armed && !load |-> local_second_pulse == (gap == SEC_CYCLES - 1))
    else $error("local second pulse off period");
  c_second: cover property (local_second_pulse);
  c_frame: cover property (|frame_reset);
  c_irq: cover property ($rose(irq));
  c_refused: cover property (pready && pslverr);
endmodule : sgts_checker
bind sgts_core sgts_checker #(.SEC_CYCLES(SEC_CYCLES)) sgts_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
  .black1_drive_en(black1_drive_en), .frame_reset(frame_reset), .black_frame_reset(black_frame_reset),
  .linear_timecode_engine_reset(linear_timecode_engine_reset), .local_second_pulse(local_second_pulse)
);
`default_nettype wire

// ===== tb.sv
/*
  self-checking bench of the time-sync core over apb.
  assumes sgts_rx_model as receiver; reference adc tied idle, sync driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sgts_pkg::*;
  localparam int unsigned SECS = 1000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e, fire;
  logic rx_pps, rx_qerr_valid, black1_drive_en, local_second_pulse, trigger_line_in, ref_sync;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] rx_qerr_ps, qerr;
  logic [2:0] frame_reset, black_frame_reset;
  logic [3:0] linear_timecode_engine_reset;
  logic [1:0] trigger_line_out;
  int err_total, checks_done;
  sgts_core #(.SEC_CYCLES(SECS)) sgts_core_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .rx_pps(rx_pps),
    .rx_qerr_valid(rx_qerr_valid), .rx_qerr_ps(rx_qerr_ps), .ref_sync(ref_sync), .ref_adc('0),
    .black1_drive_en(black1_drive_en), .frame_reset(frame_reset), .black_frame_reset(black_frame_reset),
    .linear_timecode_engine_reset(linear_timecode_engine_reset), .local_second_pulse(local_second_pulse),
    .trigger_line_in(trigger_line_in), .trigger_line_out(trigger_line_out)
  );
  sgts_rx_model sgts_rx_model_inst (
    .pclk(pclk), .presetn(presetn), .fire(fire), .qerr(qerr),
    .rx_pps(rx_pps), .rx_qerr_valid(rx_qerr_valid), .rx_qerr_ps(rx_qerr_ps)
  );
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic end_of_test();
    if (err_total == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    checks_done++;
    if (g !== x)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    chk("pready", 1, pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_ev(input bit fr, output int n);
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while ((fr ? frame_reset[0] : local_second_pulse) !== 1'b1 && n < 3000);
  endtask : wait_ev
  task automatic meas(input logic [15:0] q, output logic [31:0] p);
    int n;
    wait_ev(0, n);
    repeat (100) @(posedge pclk);
    fire <= 1'b1;
    qerr <= q;
    @(posedge pclk);
    fire <= 1'b0;
    repeat (60) @(posedge pclk);
    apb(0, A_PHASE, 0);
    p = rd;
  endtask : meas
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    chk("black1_rst", 1, black1_drive_en);
    apb(0, A_FRAME_LEN, 0);
    chk("frame_len_rst", FRAME_LEN_RST, rd);
    apb(0, 12'h0FC, 0);
    chk("unmapped_err", 1, e);
    apb(0, A_TC, 0);
    chk("tc_hidden", 0, rd);
    apb(1, A_IRQ_MASK, 32'h00000015);
    apb(0, A_IRQ_MASK, 0);
    chk("mask", 32'h00000015, rd);
  endtask : t_regs
  task automatic t_genlock();
    apb(1, A_CTRL, 32'h00000001);
    repeat (2) @(posedge pclk);
    chk("black1_off", 0, black1_drive_en);
    ref_sync <= 1'b1;
    repeat (8) @(posedge pclk);
    ref_sync <= 1'b0;
    apb(0, A_STATUS, 0);
    chk("win_busy", 32'h3, rd & 32'h3);
    repeat (80) @(posedge pclk);
    apb(0, A_IRQ_STAT, 0);
    chk("cap_done", 32'h10, rd & 32'h10);
    apb(1, A_CTRL, 32'h00000000);
    repeat (2) @(posedge pclk);
    chk("black1_on", 1, black1_drive_en);
  endtask : t_genlock
  task automatic t_time();
    int n;
    logic [31:0] s;
    apb(1, A_FRAME_LEN, 32'h0000012C);
    apb(1, A_SEC_SET, 32'h00001234);
    apb(1, A_EPOCH_LO, 32'h00000001);
    apb(1, A_CTRL, 32'h00000004);
    apb(0, A_SEC_LO, 0);
    chk("sec_load", 32'h00001234, rd);
    wait_ev(1, n);
    chk("epoch_phase", 32'h12C - SECS % 32'h12C - 32'h2, n);
    wait_ev(1, n);
    chk("frame_gap", 32'h0000012C, n);
    wait_ev(0, n);
    apb(0, A_SEC_LO, 0);
    s = rd;
    wait_ev(0, n);
    wait_ev(0, n);
    chk("sec_period", SECS, n);
    apb(0, A_SEC_LO, 0);
    chk("sec_step", s + 32'h2, rd);
  endtask : t_time
  task automatic t_phase();
    logic [31:0] p1, p2;
    int f;
    apb(1, A_IRQ_MASK, 32'h00000001);
    meas(16'h0BB8, p1);
    meas(16'h4268, p2);
    chk("qerr_removed", 32'h000036B0, p1 - p2);
    apb(0, A_FILT, 0);
    f = $signed(p1) >>> FILT_SHIFT;
    f = f + (($signed(p2) - f) >>> FILT_SHIFT);
    chk("filt", f, rd);
    chk("phase_grid", 0, (p1 + 32'h0BB8) % CLK_PERIOD_PS);
    chk("pps_irq", 1, irq);
    apb(1, A_IRQ_STAT, 32'h0000001F);
    repeat (2) @(posedge pclk);
    chk("pps_irq_clr", 0, irq);
  endtask : t_phase
  task automatic t_trig();
    apb(1, A_IRQ_MASK, 32'h00000008);
    apb(1, A_TRIG, 32'h00000009);
    repeat (2) @(posedge pclk);
    chk("trig_out", 32'h2, trigger_line_out);
    trigger_line_in <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("trig_irq", 1, irq);
    apb(1, A_IRQ_MASK, 0);
    repeat (2) @(posedge pclk);
    chk("irq_masked", 0, irq);
    trigger_line_in <= 1'b0;
    repeat (10) @(posedge pclk);
    apb(1, A_IRQ_STAT, 32'h0000001F);
    apb(1, A_IRQ_MASK, 32'h00000008);
    repeat (2) @(posedge pclk);
    chk("irq_cleared", 0, irq);
  endtask : t_trig
  // ****************************************
  // clock, watchdog, main sequence
  // ****************************************
  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    repeat (40000) @(posedge pclk);
    err_total++;
    end_of_test();
  end
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, fire, trigger_line_in, ref_sync} = 6'b000000;
    paddr = 12'h000;
    pwdata = 32'h0;
    qerr = 16'h0000;
    err_total = 0;
    checks_done = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_genlock();
    t_time();
    t_phase();
    t_trig();
    end_of_test();
  end
endmodule : tb
`default_nettype wire
